/* File: tdk_defs.svh */
// constants of the token data object key store
`ifndef TDK_DEFS_SVH
`define TDK_DEFS_SVH
`define TDK_OBJ_BYTES   81920
`define TDK_ADDR_W      17
`define TDK_PRIV_BYTES  48
`define TDK_PRIV_AW     6
`define TDK_FMT_VERSION 8'h00
`define TDK_ID_VERSION  16'h0000
`define TDK_ID_KEY1     16'h0001
`define TDK_ID_KEY4     16'h0004
`define TDK_ID_TOKEN    16'h0005
`define TDK_ID_OBJLEN   16'h0006
`define TDK_ID_LPK      16'h0007
`define TDK_ID_CTIME    16'h0008
`define TDK_ID_FPRINT   16'h0009
`define TDK_ID_KEYID    16'h000A
`define TDK_ID_TITLE    16'h000B
`define TDK_ID_COMMENT  16'h000C
`define TDK_ID_RSV_LO   16'h000D
`define TDK_ID_RSV_HI   16'h00FF
`define TDK_ID_REMOTE   16'h0100
`define TDK_LEN_VERSION 16'h0001
`define TDK_LEN_KEY     16'h0020
`define TDK_LEN_TOKEN   16'h0004
`define TDK_LEN_OBJLEN  16'h0004
`define TDK_LEN_LPK     16'h00A0
`define TDK_LEN_CTIME   16'h000A
`define TDK_LEN_FPRINT  16'h0014
`define TDK_LEN_KEYID   16'h0008
`define TDK_LEN_TXT_MAX 16'h00FF
`define TDK_LEN_REMOTE  16'h00AB
`define TDK_KEY_LAST    6'h1F
`define TDK_ROUNDS      4'hE
`endif

/* File: tdk_pkg.sv */
// types of the token data object key store
package tdk_pkg;
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_PRIME     = 4'h1,
    ST_ID_HI     = 4'h2,
    ST_ID_LO     = 4'h3,
    ST_LEN_HI    = 4'h4,
    ST_LEN_LO    = 4'h5,
    ST_PAYLOAD   = 4'h6,
    ST_KEY_PRIME = 4'h7,
    ST_KEY_LOAD  = 4'h8,
    ST_CIPHER    = 4'h9
  } tdk_state_type;
endpackage

/* File: tdk_cipher_if.sv */
// block cipher request and answer between controller and core
`timescale 1ns/10ps
interface tdk_cipher_if;
  logic         start;
  logic [255:0] key;
  logic [127:0] block;
  logic         done;
  logic [127:0] result;
  modport ctrl (output start, key, block, input done, result);
  modport core (input start, key, block, output done, result);
endinterface

/* File: tdk_byte_mem.sv */
// byte memory with one write port and a registered read port
`timescale 1ns/10ps
`include "tdk_defs.svh"
module tdk_byte_mem #(
  parameter int DEPTH = `TDK_OBJ_BYTES,
  parameter int AW    = `TDK_ADDR_W
) (
  input  wire logic          ref_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: tdk_cipher_core.sv */
// iterative 256-bit-key block cipher engine, one block per start
`timescale 1ns/10ps
`include "tdk_defs.svh"
module tdk_cipher_core
  import tdk_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst,
  tdk_cipher_if.core cif
);
  logic [127:0] s_q, s_d, rk, x;
  logic [3:0]   rnd_q, rnd_d;
  logic         run_q, run_d, done_q, done_d;
  logic [127:0] res_q, res_d;

  assign cif.done   = done_q;
  assign cif.result = res_q;

  always_comb begin
    s_d    = s_q;
    rnd_d  = rnd_q;
    run_d  = run_q;
    done_d = 1'b0;
    res_d  = res_q;
    rk     = rnd_q[0] ? cif.key[255:128] : cif.key[127:0];
    x      = s_q ^ rk ^ {124'h0, rnd_q};
    if (!run_q && cif.start) begin
      s_d   = cif.block;
      rnd_d = 4'h0;
      run_d = 1'b1;
    end else if (run_q) begin
      s_d   = {x[95:0], x[127:96]} ^ (x & {x[0], x[127:1]})
              ^ {x[6:0], x[127:7]};
      rnd_d = rnd_q + 4'h1;
      if (rnd_q == `TDK_ROUNDS - 4'h1) begin
        run_d  = 1'b0;
        done_d = 1'b1;
        res_d  = s_d;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q    <= 128'h0;
      rnd_q  <= 4'h0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
      res_q  <= 128'h0;
    end else begin
      s_q    <= s_d;
      rnd_q  <= rnd_d;
      run_q  <= run_d;
      done_q <= done_d;
      res_q  <= res_d;
    end
  end
endmodule

/* File: tdk_keystore.sv */
// token key store: data object parser, key fetch and subkey engine
`timescale 1ns/10ps
`include "tdk_defs.svh"
module tdk_keystore
  import tdk_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     obj_wr_en,
  input  wire logic [`TDK_ADDR_W-1:0]   obj_wr_addr,
  input  wire logic [7:0]               obj_wr_data,
  input  wire logic                     priv_wr_en,
  input  wire logic [`TDK_PRIV_AW-1:0]  priv_wr_addr,
  input  wire logic [7:0]               priv_wr_data,
  input  wire logic                     parse_start,
  input  wire logic                     key_req,
  input  wire logic [1:0]               key_sel,
  output logic                          busy,
  output logic                          parse_done,
  output logic                          parse_err,
  output logic                          obj_ready,
  output logic [7:0]                    format_version,
  output logic [31:0]                   obj_length,
  output logic                          subkey_valid,
  output logic [127:0]                  subkey,
  output logic                          req_refused
);
  localparam int AW = `TDK_ADDR_W;

  tdk_state_type  state_q, state_d;
  logic [AW-1:0]  ptr_q, ptr_d;
  logic [15:0]    id_q, id_d, len_q, len_d, cnt_q, cnt_d, len_new;
  logic [31:0]    objlen_q, objlen_d;
  logic           olen_seen_q, olen_seen_d;
  logic [7:0]     ver_q, ver_d;
  logic [AW-1:0]  koff_q [4];
  logic [AW-1:0]  koff_d [4];
  logic [3:0]     kseen_q, kseen_d;
  logic [255:0]   key_q, key_d;
  logic [5:0]     kcnt_q, kcnt_d;
  logic [1:0]     sel_q, sel_d;
  logic           ready_q, ready_d, busy_q, busy_d;
  logic           done_q, done_d, err_q, err_d, ref_q, ref_d;
  logic           start_q, start_d, skv_q, skv_d;
  logic [127:0]   sk_q, sk_d;
  logic [7:0]     rd_data;
  logic           wr_ok, item_end, finish, fail;
  logic [AW-1:0]  ptr_nx;

  tdk_cipher_if cif ();

  assign busy           = busy_q;
  assign parse_done     = done_q;
  assign parse_err      = err_q;
  assign obj_ready      = ready_q;
  assign format_version = ver_q;
  assign obj_length     = objlen_q;
  assign subkey_valid   = skv_q;
  assign subkey         = sk_q;
  assign req_refused    = ref_q;

  assign wr_ok     = obj_wr_en && !busy_q;
  assign ptr_nx    = ptr_q + {{(AW-1){1'b0}}, 1'b1};
  assign len_new   = {len_q[7:0], rd_data};
  assign cif.start = start_q;
  assign cif.key   = key_q;
  assign cif.block = 128'h0;

  tdk_byte_mem #(.DEPTH(`TDK_OBJ_BYTES), .AW(AW)) u_obj (
    .ref_clk (ref_clk),
    .wr_en   (wr_ok),
    .wr_addr (obj_wr_addr),
    .wr_data (obj_wr_data),
    .rd_addr (ptr_d),
    .rd_data (rd_data)
  );

  tdk_byte_mem #(.DEPTH(`TDK_PRIV_BYTES), .AW(`TDK_PRIV_AW)) u_priv (
    .ref_clk (ref_clk),
    .wr_en   (priv_wr_en && !busy_q),
    .wr_addr (priv_wr_addr),
    .wr_data (priv_wr_data),
    .rd_addr ({`TDK_PRIV_AW{1'b0}}),
    .rd_data ()
  );

  tdk_cipher_core u_core (
    .ref_clk (ref_clk),
    .rst     (rst),
    .cif     (cif)
  );

  function automatic logic len_ok(input logic [15:0] id,
                                  input logic [15:0] len);
    logic r;
    r = 1'b1;
    if (id == `TDK_ID_VERSION) begin
      r = (len == `TDK_LEN_VERSION);
    end else if (id <= `TDK_ID_KEY4) begin
      r = (len == `TDK_LEN_KEY);
    end else if (id == `TDK_ID_TOKEN) begin
      r = (len == `TDK_LEN_TOKEN);
    end else if (id == `TDK_ID_OBJLEN) begin
      r = (len == `TDK_LEN_OBJLEN);
    end else if (id == `TDK_ID_LPK) begin
      r = (len == `TDK_LEN_LPK);
    end else if (id == `TDK_ID_CTIME) begin
      r = (len == `TDK_LEN_CTIME);
    end else if (id == `TDK_ID_FPRINT) begin
      r = (len == `TDK_LEN_FPRINT);
    end else if (id == `TDK_ID_KEYID) begin
      r = (len == `TDK_LEN_KEYID);
    end else if (id == `TDK_ID_TITLE || id == `TDK_ID_COMMENT) begin
      r = (len != 16'h0000) && (len <= `TDK_LEN_TXT_MAX);
    end else if (id >= `TDK_ID_REMOTE) begin
      r = (len == `TDK_LEN_REMOTE);
    end
    return r;
  endfunction

  always_comb begin
    state_d     = state_q;
    ptr_d       = ptr_q;
    id_d        = id_q;
    len_d       = len_q;
    cnt_d       = cnt_q;
    objlen_d    = objlen_q;
    olen_seen_d = olen_seen_q;
    ver_d       = ver_q;
    koff_d      = koff_q;
    kseen_d     = kseen_q;
    key_d       = key_q;
    kcnt_d      = kcnt_q;
    sel_d       = sel_q;
    ready_d     = ready_q && !wr_ok;
    busy_d      = busy_q;
    done_d      = 1'b0;
    err_d       = err_q;
    ref_d       = 1'b0;
    start_d     = 1'b0;
    skv_d       = 1'b0;
    sk_d        = sk_q;
    item_end    = 1'b0;
    fail        = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (parse_start) begin
          state_d     = ST_PRIME;
          ptr_d       = {AW{1'b0}};
          olen_seen_d = 1'b0;
          kseen_d     = 4'h0;
          ready_d     = 1'b0;
          busy_d      = 1'b1;
          err_d       = 1'b0;
        end else if (key_req && ready_q) begin
          state_d = ST_KEY_PRIME;
          sel_d   = key_sel;
          busy_d  = 1'b1;
        end else if (key_req) begin
          ref_d = 1'b1;
        end
      end
      ST_PRIME: begin
        state_d = ST_ID_HI;
      end
      ST_ID_HI: begin
        id_d    = {8'h00, rd_data};
        ptr_d   = ptr_nx;
        state_d = ST_ID_LO;
      end
      ST_ID_LO: begin
        id_d    = {id_q[7:0], rd_data};
        ptr_d   = ptr_nx;
        state_d = ST_LEN_HI;
      end
      ST_LEN_HI: begin
        len_d   = {8'h00, rd_data};
        ptr_d   = ptr_nx;
        state_d = ST_LEN_LO;
      end
      ST_LEN_LO: begin
        len_d = len_new;
        cnt_d = len_new;
        ptr_d = ptr_nx;
        if (!len_ok(id_q, len_new)) begin
          fail = 1'b1;
        end else if (len_new == 16'h0000) begin
          item_end = 1'b1;
        end else begin
          state_d = ST_PAYLOAD;
        end
      end
      ST_PAYLOAD: begin
        if (id_q == `TDK_ID_VERSION) begin
          ver_d = rd_data;
        end
        if (id_q == `TDK_ID_OBJLEN) begin
          objlen_d = {objlen_q[23:0], rd_data};
        end
        if (id_q >= `TDK_ID_KEY1 && id_q <= `TDK_ID_KEY4 &&
            cnt_q == len_q) begin
          koff_d[id_q[1:0] - 2'h1]  = ptr_q;
          kseen_d[id_q[1:0] - 2'h1] = 1'b1;
        end
        ptr_d = ptr_nx;
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001) begin
          if (id_q == `TDK_ID_OBJLEN) begin
            olen_seen_d = 1'b1;
          end
          item_end = 1'b1;
        end
      end
      ST_KEY_PRIME: begin
        ptr_d   = koff_q[sel_q];
        kcnt_d  = 6'h00;
        state_d = ST_KEY_LOAD;
      end
      ST_KEY_LOAD: begin
        key_d  = {key_q[247:0], rd_data};
        ptr_d  = ptr_nx;
        kcnt_d = kcnt_q + 6'h01;
        if (kcnt_q == `TDK_KEY_LAST) begin
          start_d = 1'b1;
          state_d = ST_CIPHER;
        end
      end
      ST_CIPHER: begin
        if (cif.done) begin
          sk_d    = cif.result;
          skv_d   = 1'b1;
          busy_d  = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
    finish = 1'b0;
    if (item_end) begin
      if (olen_seen_d && {{(32-AW){1'b0}}, ptr_d} == objlen_d) begin
        finish = 1'b1;
      end else if ((olen_seen_d &&
                    {{(32-AW){1'b0}}, ptr_d} > objlen_d) ||
                   ptr_q == {AW{1'b1}}) begin
        fail = 1'b1;
      end else begin
        state_d = ST_ID_HI;
      end
    end
    if (finish || fail) begin
      state_d = ST_IDLE;
      busy_d  = 1'b0;
      done_d  = 1'b1;
      err_d   = fail || ver_d != `TDK_FMT_VERSION || kseen_d != 4'hF;
      ready_d = !err_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      ptr_q       <= {AW{1'b0}};
      id_q        <= 16'h0000;
      len_q       <= 16'h0000;
      cnt_q       <= 16'h0000;
      objlen_q    <= 32'h0000_0000;
      olen_seen_q <= 1'b0;
      ver_q       <= 8'h00;
      koff_q      <= '{default: {AW{1'b0}}};
      kseen_q     <= 4'h0;
      key_q       <= 256'h0;
      kcnt_q      <= 6'h00;
      sel_q       <= 2'h0;
      ready_q     <= 1'b0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
      ref_q       <= 1'b0;
      start_q     <= 1'b0;
      skv_q       <= 1'b0;
      sk_q        <= 128'h0;
    end else begin
      state_q     <= state_d;
      ptr_q       <= ptr_d;
      id_q        <= id_d;
      len_q       <= len_d;
      cnt_q       <= cnt_d;
      objlen_q    <= objlen_d;
      olen_seen_q <= olen_seen_d;
      ver_q       <= ver_d;
      koff_q      <= koff_d;
      kseen_q     <= kseen_d;
      key_q       <= key_d;
      kcnt_q      <= kcnt_d;
      sel_q       <= sel_d;
      ready_q     <= ready_d;
      busy_q      <= busy_d;
      done_q      <= done_d;
      err_q       <= err_d;
      ref_q       <= ref_d;
      start_q     <= start_d;
      skv_q       <= skv_d;
      sk_q        <= sk_d;
    end
  end

  // starts counted per request, checked below
  logic [1:0] nst_q;
  always_ff @(posedge ref_clk) begin
    if (rst || state_q == ST_KEY_PRIME) begin
      nst_q <= 2'h0;
    end else if (start_q && nst_q != 2'h3) begin
      nst_q <= nst_q + 2'h1;
    end
  end

  property p_rst_idle;
    @(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> state_q == ST_IDLE && !busy_q && !obj_ready;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("no idle");
  property p_ver;
    @(posedge ref_clk) disable iff (rst)
      done_q && ready_q |-> ver_q == `TDK_FMT_VERSION;
  endproperty
  a_ver: assert property (p_ver) else $error("bad version");
  property p_end;
    @(posedge ref_clk) disable iff (rst)
      done_q && ready_q |-> {{(32-AW){1'b0}}, ptr_q} == objlen_q;
  endproperty
  a_end: assert property (p_end) else $error("end mismatch");
  property p_keylen;
    @(posedge ref_clk) disable iff (rst)
      state_q == ST_LEN_LO && id_q >= `TDK_ID_KEY1 &&
      id_q <= `TDK_ID_KEY4 && len_new != `TDK_LEN_KEY
      |=> done_q && err_q && !ready_q;
  endproperty
  a_keylen: assert property (p_keylen) else $error("key len");
  property p_lpk;
    @(posedge ref_clk) disable iff (rst)
      state_q == ST_LEN_LO && id_q == `TDK_ID_LPK &&
      len_new != `TDK_LEN_LPK |=> err_q;
  endproperty
  a_lpk: assert property (p_lpk) else $error("lpk len");
  property p_remote;
    @(posedge ref_clk) disable iff (rst)
      state_q == ST_LEN_LO && id_q >= `TDK_ID_REMOTE &&
      len_new != `TDK_LEN_REMOTE |=> err_q;
  endproperty
  a_remote: assert property (p_remote) else $error("remote");
  property p_text;
    @(posedge ref_clk) disable iff (rst)
      state_q == ST_LEN_LO && id_q == `TDK_ID_TITLE &&
      len_new == 16'h0000 |=> err_q;
  endproperty
  a_text: assert property (p_text) else $error("title len");
  property p_sel;
    @(posedge ref_clk) disable iff (rst)
      state_q == ST_KEY_PRIME |=> ptr_q == koff_q[sel_q]
      ##32 state_q == ST_CIPHER;
  endproperty
  a_sel: assert property (p_sel) else $error("key select");
  property p_once;
    @(posedge ref_clk) disable iff (rst)
      skv_q |-> nst_q == 2'h1;
  endproperty
  a_once: assert property (p_once) else $error("cipher count");
  sequence s_last_byte;
    state_q == ST_PAYLOAD && cnt_q == 16'h0001;
  endsequence
  property p_item;
    @(posedge ref_clk) disable iff (rst)
      s_last_byte |=> state_q == ST_ID_HI || state_q == ST_IDLE;
  endproperty
  a_item: assert property (p_item) else $error("item walk");
endmodule

/* File: tdk_host_model.sv */
// host model: writes the data object and asks for subkeys
`timescale 1ns/10ps
`include "tdk_defs.svh"
module tdk_host_model (
  input  wire logic                   ref_clk,
  output logic                        obj_wr_en,
  output logic [`TDK_ADDR_W-1:0]      obj_wr_addr,
  output logic [7:0]                  obj_wr_data,
  output logic                        parse_start,
  output logic                        key_req,
  output logic [1:0]                  key_sel
);
  logic [`TDK_ADDR_W-1:0] ptr;
  initial begin
    obj_wr_en   = 1'b0;
    obj_wr_addr = '0;
    obj_wr_data = 8'h00;
    parse_start = 1'b0;
    key_req     = 1'b0;
    key_sel     = 2'h0;
    ptr         = '0;
  end
  task put_byte(input logic [7:0] b);
    @(posedge ref_clk);
    obj_wr_en   <= 1'b1;
    obj_wr_addr <= ptr;
    obj_wr_data <= b;
    ptr = ptr + 1'b1;
  endtask
  task put_item(input logic [15:0] id, input int len, input logic [7:0] s);
    put_byte(id[15:8]);
    put_byte(id[7:0]);
    put_byte(len[15:8]);
    put_byte(len[7:0]);
    for (int i = 0; i < len; i++) begin
      put_byte(s + i[7:0]);
    end
  endtask
  // items in sequence from byte 0
  task build(input logic [7:0] ver, input int k4len, input logic k3same,
             input logic [15:0] xid, input int xlen);
    int total;
    total = 379 + k4len - 32 + ((xid != 16'h0000) ? 4 + xlen : 0);
    ptr = '0;
    put_item(16'h0000, 1, ver);
    put_item(16'h0001, 32, 8'h10);
    put_item(16'h0002, 32, 8'h40);
    put_item(16'h0003, 32, k3same ? 8'h10 : 8'h70);
    put_item(16'h0004, k4len, 8'hA0);
    put_item(16'h0005, 4, 8'h01);
    put_item(16'h0006, 0, 8'h00);
    ptr = ptr - 3'h2;
    put_byte(8'h00);
    put_byte(8'h04);
    for (int i = 3; i >= 0; i--) begin
      put_byte(total[8*i +: 8]);
    end
    put_item(16'h0007, 160, 8'h20);
    put_item(16'h0008, 10, 8'h30);
    put_item(16'h0009, 20, 8'h50);
    put_item(16'h000A, 8, 8'h60);
    if (xid != 16'h0000) begin
      put_item(xid, xlen, 8'h90);
    end
    @(posedge ref_clk);
    obj_wr_en   <= 1'b0;
    obj_wr_data <= ~obj_wr_data;
  endtask
  task start_parse();
    @(posedge ref_clk);
    parse_start <= 1'b1;
    @(posedge ref_clk);
    parse_start <= 1'b0;
  endtask
  // one fresh request per packet, nothing kept
  task request(input logic [1:0] sel);
    @(posedge ref_clk);
    key_req <= 1'b1;
    key_sel <= sel;
    @(posedge ref_clk);
    key_req <= 1'b0;
    key_sel <= ~sel;
  endtask
endmodule

/* File: test_tdk_keystore.sv */
// self-checking bench of the token key store
`timescale 1ns/10ps
`include "tdk_defs.svh"
module test_tdk_keystore;
  logic                       ref_clk;
  logic                       rst;
  logic                       obj_wr_en;
  logic [`TDK_ADDR_W-1:0]     obj_wr_addr;
  logic [7:0]                 obj_wr_data;
  logic                       priv_wr_en;
  logic [`TDK_PRIV_AW-1:0]    priv_wr_addr;
  logic [7:0]                 priv_wr_data;
  logic                       parse_start;
  logic                       key_req;
  logic [1:0]                 key_sel;
  logic                       busy;
  logic                       parse_done;
  logic                       parse_err;
  logic                       obj_ready;
  logic [7:0]                 format_version;
  logic [31:0]                obj_length;
  logic                       subkey_valid;
  logic [127:0]               subkey;
  logic                       req_refused;
  logic [127:0]               sk [0:4];
  logic [127:0]               sk_ref;
  int                         n_fail;
  int                         n_tests;

  tdk_keystore i_tdk_keystore (.ref_clk(ref_clk), .rst(rst),
    .obj_wr_en(obj_wr_en), .obj_wr_addr(obj_wr_addr),
    .obj_wr_data(obj_wr_data), .priv_wr_en(priv_wr_en),
    .priv_wr_addr(priv_wr_addr), .priv_wr_data(priv_wr_data),
    .parse_start(parse_start), .key_req(key_req), .key_sel(key_sel),
    .busy(busy), .parse_done(parse_done), .parse_err(parse_err),
    .obj_ready(obj_ready), .format_version(format_version),
    .obj_length(obj_length), .subkey_valid(subkey_valid),
    .subkey(subkey), .req_refused(req_refused));
  tdk_host_model i_tdk_host_model (.ref_clk(ref_clk),
    .obj_wr_en(obj_wr_en), .obj_wr_addr(obj_wr_addr),
    .obj_wr_data(obj_wr_data), .parse_start(parse_start),
    .key_req(key_req), .key_sel(key_sel));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task print_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task run_parse(input int len, input int walk, input logic err);
    int n;
    i_tdk_host_model.start_parse();
    n = 0;
    while (parse_done !== 1'b1) begin
      @(posedge ref_clk);
      n++;
      if (n > 2000) begin
        chk(n, walk);
        print_verdict();
      end
    end
    chk(n >= walk + 2 && n <= walk + 4, 1'b1);
    chk(parse_err, err);
    chk(obj_ready, !err);
    if (!err) begin
      chk(obj_length, len);
      chk(format_version, `TDK_FMT_VERSION);
    end
  endtask
  task get_key(input logic [1:0] sel, output logic [127:0] k);
    int pulses;
    int first;
    logic b;
    pulses = 0;
    first = 0;
    b = 1'b0;
    k = '0;
    i_tdk_host_model.request(sel);
    for (int n = 1; n <= 60; n++) begin
      @(posedge ref_clk);
      if (n == 10) b = busy;
      if (subkey_valid === 1'b1) begin
        pulses++;
        if (first == 0) first = n;
        k = subkey;
      end
    end
    chk(b, 1'b1);
    chk(pulses, 1);
    chk(first >= 49 && first <= 51, 1'b1);
  endtask
  task t_base();
    i_tdk_host_model.build(8'h00, 32, 1'b0, 16'h0000, 0);
    chk(obj_ready, 1'b0);
    run_parse(379, 379, 1'b0);
    for (int i = 0; i < 4; i++) get_key(i[1:0], sk[i]);
    get_key(2'h0, sk[4]);
    chk(sk[4], sk[0]);
    chk(sk[0] === sk[1] || sk[1] === sk[2] || sk[2] === sk[3], 1'b0);
    sk_ref = sk[0];
    $display("test base done");
  endtask
  task t_same();
    i_tdk_host_model.build(8'h00, 32, 1'b1, 16'h0000, 0);
    run_parse(379, 379, 1'b0);
    get_key(2'h2, sk[2]);
    chk(sk[2], sk_ref);
    $display("test key select done");
  endtask
  task t_priv();
    for (int i = 0; i < `TDK_PRIV_BYTES; i++) begin
      @(posedge ref_clk);
      priv_wr_en   <= 1'b1;
      priv_wr_addr <= i[5:0];
      priv_wr_data <= 8'hC3 ^ i[7:0];
    end
    @(posedge ref_clk);
    priv_wr_en <= 1'b0;
    i_tdk_host_model.build(8'h00, 32, 1'b0, 16'h0000, 0);
    run_parse(379, 379, 1'b0);
    get_key(2'h0, sk[0]);
    chk(sk[0], sk_ref);
    $display("test private store done");
  endtask
  task t_extra();
    logic [15:0] ids [0:8];
    int          lens [0:8];
    logic        errs [0:8];
    ids  = '{16'h0080, 16'h000D, 16'h0100, 16'hFFFF,
             16'h000B, 16'h000B, 16'h000C, 16'h000C, 16'h0007};
    lens = '{3, 0, 171, 170, 255, 0, 1, 256, 159};
    errs = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 9; i++) begin
      i_tdk_host_model.build(8'h00, 32, 1'b0, ids[i], lens[i]);
      run_parse(383 + lens[i], errs[i] ? 383 : 383 + lens[i],
                errs[i]);
    end
    $display("test optional items done");
  endtask
  task t_bad();
    i_tdk_host_model.build(8'h01, 32, 1'b0, 16'h0000, 0);
    run_parse(379, 379, 1'b1);
    i_tdk_host_model.build(8'h00, 31, 1'b0, 16'h0000, 0);
    run_parse(378, 117, 1'b1);
    $display("test bad items done");
  endtask
  task t_refuse();
    int r;
    int v;
    r = 0;
    v = 0;
    i_tdk_host_model.request(2'h1);
    for (int n = 1; n <= 60; n++) begin
      @(posedge ref_clk);
      if (req_refused === 1'b1 && n <= 3) r++;
      if (subkey_valid === 1'b1) v++;
    end
    chk(r, 1);
    chk(v, 0);
    $display("test refusal done");
  endtask
  task t_reset();
    i_tdk_host_model.build(8'h00, 32, 1'b0, 16'h0000, 0);
    i_tdk_host_model.start_parse();
    repeat (20) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({busy, parse_done, obj_ready, parse_err}, 4'h0);
    chk(obj_length, 32'h0000_0000);
    run_parse(379, 379, 1'b0);
    $display("test reset done");
  endtask
  initial begin
    n_fail       = 0;
    n_tests      = 0;
    rst          = 1'b1;
    priv_wr_en   = 1'b0;
    priv_wr_addr = '0;
    priv_wr_data = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_base();
    t_same();
    t_priv();
    t_extra();
    t_bad();
    t_refuse();
    t_reset();
    print_verdict();
  end
endmodule
